/* File: ssdcr_pkg.sv */
/*
 * Shared constants and carrier types of the serial port status, data and
 * CRC register block. Assumes nothing beyond a SystemVerilog compiler.
 */
package ssdcr_pkg;
	// Register byte offsets
	localparam logic [4:0] OFF_CONTROL_ONE = 5'h00;
	localparam logic [4:0] OFF_CONTROL_TWO = 5'h04;
	localparam logic [4:0] OFF_PORT_STATUS = 5'h08;
	localparam logic [4:0] OFF_DATA_BUFFERS = 5'h0C;
	localparam logic [4:0] OFF_CRC_POLYNOMIAL = 5'h10;
	localparam logic [4:0] OFF_RECEIVE_CRC = 5'h14;
	localparam logic [4:0] OFF_TRANSMIT_CRC = 5'h18;
	// Field positions
	localparam int CR1_CRC_ENABLE = 13;
	localparam int CR1_CRC_NEXT = 12;
	localparam int CR1_FRAME_WIDTH = 11;
	localparam int CR1_PORT_ENABLE = 6;
	localparam int CR1_MASTER = 2;
	localparam int SR_BUSY = 7;
	localparam int SR_OVERRUN = 6;
	localparam int SR_MODE_FAULT = 5;
	localparam int SR_CRC_MISMATCH = 4;
	localparam int SR_TX_EMPTY = 1;
	localparam int SR_RX_FULL = 0;
	// Reset values and masks
	localparam logic [15:0] RST_CONTROL = 16'h0000;
	localparam logic [15:0] RST_DATA = 16'h0000;
	localparam logic [15:0] RST_CRC_POLY = 16'h0007;
	localparam logic [15:0] RST_CRC = 16'h0000;
	localparam logic [15:0] CONTROL_TWO_MASK = 16'h00E7;
	// Frame lengths in bits
	localparam logic [4:0] FRAME_BITS_NARROW = 5'h08;
	localparam logic [4:0] FRAME_BITS_WIDE = 5'h10;

	typedef struct packed {
		logic sel;
		logic write;
		logic [4:0] addr;
		logic [31:0] wdata;
	} ssdcr_bus_req_s;

	typedef struct packed {
		logic valid;
		logic [31:0] rdata;
	} ssdcr_bus_resp_s;
endpackage

/* File: ssdcr_crc.sv */
/*
 * Serial CRC engine: folds one frame into the accumulator, one bit per clock.
 * Assumes start pulses are spaced by at least one frame length of clocks.
 */
`timescale 1ns/1ps
module ssdcr_crc import ssdcr_pkg::*; (
	input wire logic clk, // Bus clock
	input wire logic reset, // Async reset, high
	input wire logic clear, // Zero the accumulator
	input wire logic start, // Fold word in
	input wire logic wide, // 16-bit frames
	input wire logic [15:0] word, // Frame data
	input wire logic [15:0] poly, // Polynomial
	output logic [15:0] crc, // Accumulator
	output logic busy // Folding in progress
);
	typedef struct packed {
		logic [15:0] crc;
		logic [15:0] data;
		logic [4:0] count;
	} ssdcr_crc_s;

	ssdcr_crc_s st;
	ssdcr_crc_s next_st;

	always_comb begin
		logic fb;
		logic [15:0] shifted;
		next_st = st;
		fb = (wide ? st.crc[15] : st.crc[7]) ^ st.data[15];
		shifted = {st.crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
		if (clear) begin
			next_st.crc = RST_CRC;
			next_st.count = 5'h00;
		end else if (start) begin
			next_st.data = wide ? word : {word[7:0], 8'h00};
			next_st.count = wide ? FRAME_BITS_WIDE : FRAME_BITS_NARROW;
		end else if (st.count != 5'h00) begin
			// Narrow frames keep an 8-bit remainder
			next_st.crc = wide ? shifted : {8'h00, shifted[7:0]};
			next_st.data = {st.data[14:0], 1'b0};
			next_st.count = 5'(st.count - 5'h01);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign crc = st.crc;
	assign busy = st.count != 5'h00;
endmodule // ssdcr_crc

/* File: ssdcr_link.sv */
/*
 * Link side shifter on the serial clock: MSB first, samples on the rising
 * edge and updates its output on the rising edge. Assumes txWord and wide are
 * stable at the first edge of each frame; the link clock may stop between.
 */
`timescale 1ns/1ps
module ssdcr_link import ssdcr_pkg::*; (
	input wire logic linkClk, // Serial clock
	input wire logic reset, // Async reset, high
	input wire logic frameSelN, // Frame select, low
	input wire logic serialIn, // Serial data in
	input wire logic wide, // 16-bit frames
	input wire logic [15:0] txWord, // Word to send
	output logic serialOut, // Serial data out
	output logic [15:0] rxWord, // Last word taken
	output logic doneToggle, // Flips per frame
	output logic inFrame // Frame under way
);
	typedef struct packed {
		logic [15:0] txShift;
		logic [14:0] rxShift;
		logic [15:0] rxWord;
		logic [4:0] count;
		logic doneToggle;
		logic inFrame;
		logic serialOut;
	} ssdcr_link_s;

	ssdcr_link_s st;
	ssdcr_link_s next_st;

	always_comb begin
		logic [15:0] aligned;
		logic [4:0] last;
		next_st = st;
		aligned = wide ? txWord : {txWord[7:0], 8'h00};
		last = 5'((wide ? FRAME_BITS_WIDE : FRAME_BITS_NARROW) - 5'h01);
		if (frameSelN) begin
			next_st.count = 5'h00;
			next_st.inFrame = 1'b0;
		end else begin
			next_st.rxShift = {st.rxShift[13:0], serialIn};
			if (st.count == 5'h00) begin
				next_st.serialOut = aligned[15];
				next_st.txShift = {aligned[14:0], 1'b0};
			end else begin
				next_st.serialOut = st.txShift[15];
				next_st.txShift = {st.txShift[14:0], 1'b0};
			end
			if (st.count == last) begin
				// Narrow frames take zero in the upper byte
				next_st.rxWord = wide ? {st.rxShift, serialIn}
					: {8'h00, st.rxShift[6:0], serialIn};
				next_st.doneToggle = ~st.doneToggle;
				next_st.count = 5'h00;
				next_st.inFrame = 1'b0;
			end else begin
				next_st.count = 5'(st.count + 5'h01);
				next_st.inFrame = 1'b1;
			end
		end
	end

	always_ff @(posedge linkClk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign serialOut = st.serialOut;
	assign rxWord = st.rxWord;
	assign doneToggle = st.doneToggle;
	assign inFrame = st.inFrame;
endmodule // ssdcr_link

/* File: ssdcr_regs.sv */
/*
 * Status, data buffer and CRC registers of the serial port on the bus clock,
 * with the link shifter on its own clock. Assumes one register request per
 * cycle on busReq and a mode fault pulse from the select logic on clk.
 */
// Functional notes
// - Overrun sets bit 6, held until cleared
// - Mode fault sets bit 5, software clears
// - CRC mismatch sets bit 4, write zero clears
// - Bit 1 high while transmit buffer empty
// - Bit 0 high while receive buffer unread
// - Data write fills transmit, read returns receive
// - Narrow frames: low byte only, upper reads zero
// - Wide frames: all sixteen bits moved
// - Polynomial resets to 7, writable
// - Receive CRC accumulates, cleared on enable write
// - Transmit CRC accumulates, cleared on enable write
// - CRCs fold serially with programmed polynomial
// - Narrow frames use 8-bit CRC, wide 16
// - Data read then status read clears overrun
// - Frame width bit: zero narrow, one wide
// - Half-word and word accesses accepted
`timescale 1ns/1ps
module ssdcr_regs import ssdcr_pkg::*; (
	input wire logic clk, // Bus clock, 100 MHz
	input wire logic reset, // Async reset, high
	input wire ssdcr_bus_req_s busReq, // Register request
	output ssdcr_bus_resp_s busResp, // Register answer
	input wire logic linkClk, // Serial clock
	input wire logic frameSelN, // Frame select, low
	input wire logic serialIn, // Serial data in
	output logic serialOut, // Serial data out
	input wire logic modeFaultEvent, // Mode fault pulse
	output logic portEnable, // Port enabled
	output logic frameWide, // 16-bit frames
	output logic crcEnable, // CRC enabled
	output logic busyFlag // Port busy
);
	typedef struct packed {
		logic [15:0] controlOne;
		logic [15:0] controlTwo;
		logic [15:0] crc_poly_value;
		logic [15:0] txBuffer;
		logic [15:0] txHold;
		logic [15:0] rxBuffer;
		logic txFull;
		logic holdFresh;
		logic holdIsCrc;
		logic sendingCrc;
		logic rxFull;
		logic overrun;
		logic modeFault;
		logic crcMismatch;
		logic ovrArmed;
		logic modfArmed;
		logic [2:0] doneSync;
		logic [2:0] frameSync;
		logic busy;
		ssdcr_bus_resp_s resp;
	} ssdcr_regs_s;

	ssdcr_regs_s st;
	ssdcr_regs_s next_st;

	logic [15:0] linkRxWord;
	logic linkDone;
	logic linkInFrame;
	logic [15:0] rx_crc_value;
	logic [15:0] tx_crc_value;
	logic rxCrcBusy;
	logic txCrcBusy;
	logic access;
	logic rd;
	logic wr;
	logic take;
	logic consumed;
	logic moveData;
	logic moveCrc;
	logic crcClear;
	logic rxCrcStart;
	logic txCrcStart;
	logic wideNow;
	logic crcOn;

	// Upper half-word of any register is reserved: no effect there
	assign access = busReq.sel && busReq.addr[1:0] == 2'b00;
	assign rd = access && !busReq.write;
	assign wr = access && busReq.write;
	assign wideNow = st.controlOne[CR1_FRAME_WIDTH];
	assign crcOn = st.controlOne[CR1_CRC_ENABLE];
	assign take = (st.doneSync[1] ^ st.doneSync[2])
		&& st.controlOne[CR1_PORT_ENABLE];
	assign consumed = st.frameSync[1] && !st.frameSync[2];
	assign moveData = !st.holdFresh && st.txFull;
	assign moveCrc = !st.holdFresh && !st.txFull && crcOn
		&& st.controlOne[CR1_CRC_NEXT];
	// Any write of one to the enable bit restarts both sums
	assign crcClear = wr && busReq.addr == OFF_CONTROL_ONE
		&& busReq.wdata[CR1_CRC_ENABLE];
	assign rxCrcStart = take && crcOn && !st.sendingCrc;
	assign txCrcStart = moveData && crcOn;

	ssdcr_link u_link (
		.linkClk(linkClk),
		.reset(reset),
		.frameSelN(frameSelN),
		.serialIn(serialIn),
		.wide(wideNow),
		.txWord(st.txHold),
		.serialOut(serialOut),
		.rxWord(linkRxWord),
		.doneToggle(linkDone),
		.inFrame(linkInFrame)
	);

	ssdcr_crc u_rx_crc (
		.clk(clk),
		.reset(reset),
		.clear(crcClear),
		.start(rxCrcStart),
		.wide(wideNow),
		.word(linkRxWord),
		.poly(st.crc_poly_value),
		.crc(rx_crc_value),
		.busy(rxCrcBusy)
	);

	ssdcr_crc u_tx_crc (
		.clk(clk),
		.reset(reset),
		.clear(crcClear),
		.start(txCrcStart),
		.wide(wideNow),
		.word(st.txBuffer),
		.poly(st.crc_poly_value),
		.crc(tx_crc_value),
		.busy(txCrcBusy)
	);

	always_comb begin
		logic [15:0] statusWord;
		logic [15:0] readWord;
		next_st = st;
		statusWord = 16'h0000;
		readWord = 16'h0000;
		statusWord[SR_BUSY] = st.busy;
		statusWord[SR_OVERRUN] = st.overrun;
		statusWord[SR_MODE_FAULT] = st.modeFault;
		statusWord[SR_CRC_MISMATCH] = st.crcMismatch;
		statusWord[SR_TX_EMPTY] = !st.txFull;
		statusWord[SR_RX_FULL] = st.rxFull;
		case (busReq.addr)
			OFF_CONTROL_ONE: readWord = st.controlOne;
			OFF_CONTROL_TWO: readWord = st.controlTwo;
			OFF_PORT_STATUS: readWord = statusWord;
			OFF_DATA_BUFFERS: readWord = st.rxBuffer;
			OFF_CRC_POLYNOMIAL: readWord = st.crc_poly_value;
			OFF_RECEIVE_CRC: readWord = rx_crc_value;
			OFF_TRANSMIT_CRC: readWord = tx_crc_value;
			default: readWord = 16'h0000;
		endcase
		// Synchronisers: first stage feeds only the second
		next_st.doneSync = {st.doneSync[1:0], linkDone};
		next_st.frameSync = {st.frameSync[1:0], linkInFrame};
		next_st.resp.valid = busReq.sel;
		if (busReq.sel && !busReq.write) begin
			next_st.resp.rdata = access ? {16'h0000, readWord} : 32'h0;
		end
		// Frame start frees the hold first, so a refill in that cycle sticks
		if (consumed) begin
			next_st.holdFresh = 1'b0;
			next_st.sendingCrc = st.holdIsCrc;
			next_st.holdIsCrc = 1'b0;
		end
		// Move a waiting word, or the CRC after the last one, to the shifter
		if (moveData) begin
			next_st.txHold = st.txBuffer;
			next_st.txFull = 1'b0;
			next_st.holdFresh = 1'b1;
			next_st.holdIsCrc = 1'b0;
		end else if (moveCrc) begin
			next_st.txHold = tx_crc_value;
			next_st.holdFresh = 1'b1;
			next_st.holdIsCrc = 1'b1;
			next_st.controlOne[CR1_CRC_NEXT] = 1'b0;
		end
		// Clears by software sequences
		if (rd && busReq.addr == OFF_PORT_STATUS) begin
			next_st.modfArmed = 1'b1;
			if (st.ovrArmed) begin
				next_st.overrun = 1'b0;
				next_st.ovrArmed = 1'b0;
			end
		end
		if (rd && busReq.addr == OFF_DATA_BUFFERS) begin
			next_st.rxFull = 1'b0;
			next_st.ovrArmed = st.overrun;
		end
		if (wr) begin
			case (busReq.addr)
				OFF_CONTROL_ONE: begin
					next_st.controlOne = busReq.wdata[15:0];
					if (st.modfArmed) begin
						next_st.modeFault = 1'b0;
						next_st.modfArmed = 1'b0;
					end
				end
				OFF_CONTROL_TWO: begin
					next_st.controlTwo = busReq.wdata[15:0] & CONTROL_TWO_MASK;
				end
				OFF_PORT_STATUS: begin
					next_st.modfArmed = 1'b1;
					if (!busReq.wdata[SR_CRC_MISMATCH]) begin
						next_st.crcMismatch = 1'b0;
					end
				end
				OFF_DATA_BUFFERS: begin
					next_st.txBuffer = wideNow ? busReq.wdata[15:0]
						: {8'h00, busReq.wdata[7:0]};
					next_st.txFull = 1'b1;
				end
				OFF_CRC_POLYNOMIAL: begin
					next_st.crc_poly_value = busReq.wdata[15:0];
				end
				default: begin
				end
			endcase
		end
		// Hardware sets win over the clears above
		if (take) begin
			next_st.sendingCrc = 1'b0;
			if (st.rxFull && !(rd && busReq.addr == OFF_DATA_BUFFERS)) begin
				next_st.overrun = 1'b1;
			end else begin
				next_st.rxBuffer = linkRxWord;
				next_st.rxFull = 1'b1;
			end
			if (st.sendingCrc && crcOn && linkRxWord != rx_crc_value) begin
				next_st.crcMismatch = 1'b1;
			end
		end
		if (modeFaultEvent) begin
			next_st.modeFault = 1'b1;
			next_st.modfArmed = 1'b0;
			next_st.controlOne[CR1_PORT_ENABLE] = 1'b0;
			next_st.controlOne[CR1_MASTER] = 1'b0;
		end
		next_st.busy = st.txFull || st.holdFresh || st.frameSync[1]
			|| take || rxCrcBusy || txCrcBusy;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st <= '0;
			st.controlOne <= RST_CONTROL;
			st.controlTwo <= RST_CONTROL;
			st.txBuffer <= RST_DATA;
			st.txHold <= RST_DATA;
			st.rxBuffer <= RST_DATA;
			st.crc_poly_value <= RST_CRC_POLY;
		end else begin
			st <= next_st;
		end
	end

	assign busResp = st.resp;
	assign portEnable = st.controlOne[CR1_PORT_ENABLE];
	assign frameWide = st.controlOne[CR1_FRAME_WIDTH];
	assign crcEnable = st.controlOne[CR1_CRC_ENABLE];
	assign busyFlag = st.busy;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_overrun_set;
		take && st.rxFull && !rd |=> st.overrun && st.rxBuffer == $past(st.rxBuffer);
	endproperty
	a_overrun_set: assert property (p_overrun_set)
		else $error("overrun not flagged or buffer overwritten");

	property p_overrun_clear;
		st.ovrArmed && rd && busReq.addr == OFF_PORT_STATUS && !take |=> !st.overrun;
	endproperty
	a_overrun_clear: assert property (p_overrun_clear)
		else $error("overrun kept after data then status read");

	property p_fault_set;
		modeFaultEvent |=> st.modeFault ##1 st.modeFault || $past(wr);
	endproperty
	a_fault_set: assert property (p_fault_set)
		else $error("mode fault not flagged");

	property p_fault_clear;
		st.modfArmed && wr && busReq.addr == OFF_CONTROL_ONE
			&& !modeFaultEvent |=> !st.modeFault;
	endproperty
	a_fault_clear: assert property (p_fault_clear)
		else $error("mode fault kept after clearing sequence");

	property p_mismatch;
		take && st.sendingCrc && crcOn && linkRxWord != rx_crc_value |=> st.crcMismatch;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("crc mismatch not flagged");

	property p_tx_full;
		wr && busReq.addr == OFF_DATA_BUFFERS && st.holdFresh |=> st.txFull;
	endproperty
	a_tx_full: assert property (p_tx_full)
		else $error("transmit empty shown after write");

	property p_rx_read;
		rd && busReq.addr == OFF_DATA_BUFFERS && !take |=> !st.rxFull;
	endproperty
	a_rx_read: assert property (p_rx_read)
		else $error("receive full kept after data read");

	property p_rx_narrow;
		take && !st.rxFull && !wideNow |=> st.rxFull && st.rxBuffer[15:8] == 8'h00;
	endproperty
	a_rx_narrow: assert property (p_rx_narrow)
		else $error("narrow frame upper byte not zero");

	property p_crc_clear;
		crcClear |=> rx_crc_value == RST_CRC && tx_crc_value == RST_CRC;
	endproperty
	a_crc_clear: assert property (p_crc_clear)
		else $error("crc sums not cleared on enable write");

	property p_poly_write;
		wr && busReq.addr == OFF_CRC_POLYNOMIAL |=> st.crc_poly_value == $past(busReq.wdata[15:0]);
	endproperty
	a_poly_write: assert property (p_poly_write)
		else $error("polynomial not stored");
endmodule // ssdcr_regs

/* File: ssdcr_link_master.sv */
/*
 * External serial master model for the status, data and CRC register block.
 * Assumes the block shifts MSB first and updates its output on rising edges.
 */
`timescale 1ns/1ps
module ssdcr_link_master (
	output logic linkClk, // Serial clock, runs only within frames
	output logic frameSelN, // Frame select, low
	output logic serialIn, // Data to the block
	input wire logic serialOut // Data from the block
);
	initial begin
		linkClk = 1'b0;
		frameSelN = 1'b1;
		serialIn = 1'b1;
	end

	// One frame of n bits, MSB first, reply sampled on falling edges
	task automatic xfer(input logic [15:0] txw, input int n,
		output logic [15:0] rxw);
		rxw = 16'h0000;
		#7 frameSelN = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serialIn = txw[i];
			#32 linkClk = 1'b1;
			#32 linkClk = 1'b0;
			rxw[i] = serialOut;
		end
		#16 frameSelN = 1'b1;
		// Released line must not keep showing the last bit
		serialIn = ~txw[0];
	endtask
endmodule // ssdcr_link_master

/* File: ssdcr_regs_tb_top.sv */
/*
 * Self-checking bench of the serial port status, data and CRC registers.
 * Assumes the register bus answers one cycle after each request.
 */
`timescale 1ns/1ps
module ssdcr_regs_tb_top import ssdcr_pkg::*; ;
	logic clk, reset, linkClk, frameSelN, serialIn, serialOut;
	logic modeFaultEvent, portEnable, frameWide, crcEnable, busyFlag;
	ssdcr_bus_req_s busReq;
	ssdcr_bus_resp_s busResp;
	int errTotal = 0;
	int nCompared = 0;
	int cyc = 0;
	logic [15:0] lfsr = 16'h0046;

	ssdcr_regs i_ssdcr_regs (.clk(clk), .reset(reset), .busReq(busReq),
		.busResp(busResp), .linkClk(linkClk), .frameSelN(frameSelN),
		.serialIn(serialIn), .serialOut(serialOut),
		.modeFaultEvent(modeFaultEvent), .portEnable(portEnable),
		.frameWide(frameWide), .crcEnable(crcEnable), .busyFlag(busyFlag));
	ssdcr_link_master i_ssdcr_link_master (.linkClk(linkClk),
		.frameSelN(frameSelN), .serialIn(serialIn), .serialOut(serialOut));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finalReport();
		$display("compared %0d mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			errTotal++;
			$display("[FAIL] %0t run too long", $time);
			finalReport();
		end
	end

	function automatic void rnd(output logic [15:0] v);
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		v = lfsr;
	endfunction

	// Expected CRC: MSB first, no reflection
	function automatic logic [15:0] crcFold(input logic [15:0] c,
		input logic [15:0] d, input logic [15:0] p, input int n);
		logic fb;
		for (int i = n - 1; i >= 0; i--) begin
			fb = c[n - 1] ^ d[i];
			c = c << 1;
			if (fb) c = c ^ p;
		end
		return (n == 8) ? (c & 16'h00FF) : c;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		nCompared++;
		if (got !== exp) begin
			errTotal++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [15:0] d, output logic [15:0] rd);
		@(posedge clk);
		busReq <= '{1'b1, wr, a, {16'h0000, d}};
		@(posedge clk);
		busReq.sel <= 1'b0;
		#1 rd = busResp.rdata[15:0];
		chk({15'h0000, busResp.valid}, 16'h0001, "bus answer");
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [15:0] m,
		input logic [15:0] e, input string what);
		logic [15:0] r;
		bus(1'b0, a, 16'h0000, r);
		chk(r & m, e, what);
	endtask

	task automatic waitBit(input int b, input logic v);
		logic [15:0] s;
		for (int i = 0; i < 40; i++) begin
			bus(1'b0, OFF_PORT_STATUS, 16'h0000, s);
			if (s[b] === v) return;
		end
		errTotal++;
		$display("[FAIL] %0t status bit %0d stuck", $time, b);
	endtask

	initial begin
		logic [15:0] a, b, c, m, p, got;
		reset = 1'b1;
		busReq = '0;
		modeFaultEvent = 1'b0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rdc(OFF_PORT_STATUS, 16'hFFFF, 16'h0002, "status reset");
		rdc(OFF_DATA_BUFFERS, 16'hFFFF, 16'h0000, "data reset");
		rdc(OFF_CRC_POLYNOMIAL, 16'hFFFF, 16'h0007, "poly reset");
		rdc(OFF_RECEIVE_CRC, 16'hFFFF, 16'h0000, "rx crc reset");
		rdc(OFF_TRANSMIT_CRC, 16'hFFFF, 16'h0000, "tx crc reset");
		wr(5'h1C, 16'hFFFF);
		rdc(5'h1C, 16'hFFFF, 16'h0000, "unmapped");
		wr(5'h02, 16'hFFFF);
		rdc(OFF_CONTROL_ONE, 16'hFFFF, 16'h0000, "upper half write");
		rdc(5'h0A, 16'hFFFF, 16'h0000, "upper half read");
		wr(OFF_RECEIVE_CRC, 16'hFFFF);
		rdc(OFF_RECEIVE_CRC, 16'hFFFF, 16'h0000, "crc read-only");
		rnd(p);
		p = p | 16'h0001;
		wr(OFF_CRC_POLYNOMIAL, p);
		rdc(OFF_CRC_POLYNOMIAL, 16'hFFFF, p, "poly write");
		// Narrow frames, second word waits in the buffer
		wr(OFF_CONTROL_ONE, 16'h0040);
		chk({14'h0000, portEnable, frameWide}, 16'h0002, "narrow on");
		rnd(a);
		rnd(b);
		rnd(c);
		wr(OFF_DATA_BUFFERS, a);
		wr(OFF_DATA_BUFFERS, b);
		rdc(OFF_PORT_STATUS, 16'h0002, 16'h0000, "tx held");
		i_ssdcr_link_master.xfer(c, 8, got);
		chk(got, a & 16'h00FF, "tx narrow");
		waitBit(SR_RX_FULL, 1'b1);
		rdc(OFF_PORT_STATUS, 16'h0002, 16'h0002, "tx emptied");
		rdc(OFF_DATA_BUFFERS, 16'hFFFF, c & 16'h00FF, "rx narrow");
		rdc(OFF_PORT_STATUS, 16'h0001, 16'h0000, "rx read");
		// Overrun: third frame lands on an unread word
		rnd(m);
		i_ssdcr_link_master.xfer(m, 8, got);
		chk(got, b & 16'h00FF, "second word");
		waitBit(SR_RX_FULL, 1'b1);
		i_ssdcr_link_master.xfer(~m, 8, got);
		repeat (10) @(posedge clk);
		rdc(OFF_PORT_STATUS, 16'h0040, 16'h0040, "overrun set");
		rdc(OFF_DATA_BUFFERS, 16'hFFFF, m & 16'h00FF, "word kept");
		bus(1'b0, OFF_PORT_STATUS, 16'h0000, got);
		rdc(OFF_PORT_STATUS, 16'h0040, 16'h0000, "overrun clear");
		// Mode fault
		@(posedge clk);
		modeFaultEvent <= 1'b1;
		@(posedge clk);
		modeFaultEvent <= 1'b0;
		rdc(OFF_PORT_STATUS, 16'h0020, 16'h0020, "fault set");
		chk({15'h0000, portEnable}, 16'h0000, "fault stops port");
		wr(OFF_CONTROL_ONE, 16'h2800);
		rdc(OFF_PORT_STATUS, 16'h0020, 16'h0000, "fault clear");
		// Wide frame with CRC folding
		wr(OFF_CONTROL_ONE, 16'h2840);
		chk({13'h0000, crcEnable, frameWide, portEnable}, 16'h0007, "wide on");
		rnd(a);
		rnd(m);
		wr(OFF_DATA_BUFFERS, a);
		i_ssdcr_link_master.xfer(m, 16, got);
		chk(got, a, "tx wide");
		waitBit(SR_RX_FULL, 1'b1);
		rdc(OFF_DATA_BUFFERS, 16'hFFFF, m, "rx wide");
		waitBit(SR_BUSY, 1'b0);
		repeat (20) @(posedge clk);
		c = crcFold(16'h0000, m, p, 16);
		rdc(OFF_RECEIVE_CRC, 16'hFFFF, c, "rx crc");
		chk({15'h0000, busyFlag}, 16'h0000, "busy pin");
		c = crcFold(16'h0000, a, p, 16);
		rdc(OFF_TRANSMIT_CRC, 16'hFFFF, c, "tx crc");
		// CRC phase: accumulators cleared, wrong CRC received
		wr(OFF_CONTROL_ONE, 16'h3840);
		rdc(OFF_RECEIVE_CRC, 16'hFFFF, 16'h0000, "crc cleared");
		i_ssdcr_link_master.xfer(16'h0001, 16, got);
		chk(got, 16'h0000, "crc frame sent");
		waitBit(SR_BUSY, 1'b0);
		repeat (10) @(posedge clk);
		rdc(OFF_PORT_STATUS, 16'h0010, 16'h0010, "crc mismatch");
		wr(OFF_PORT_STATUS, 16'h0000);
		rdc(OFF_PORT_STATUS, 16'h0010, 16'h0000, "mismatch clear");
		// Narrow frame with 8-bit CRC, width set while disabled
		rdc(OFF_DATA_BUFFERS, 16'hFFFF, 16'h0001, "crc frame rx");
		wr(OFF_CONTROL_ONE, 16'h2000);
		wr(OFF_CONTROL_ONE, 16'h2040);
		rnd(a);
		rnd(m);
		wr(OFF_DATA_BUFFERS, a);
		i_ssdcr_link_master.xfer(m, 8, got);
		chk(got, a & 16'h00FF, "tx narrow crc");
		waitBit(SR_BUSY, 1'b0);
		repeat (20) @(posedge clk);
		c = crcFold(16'h0000, m, p, 8);
		rdc(OFF_RECEIVE_CRC, 16'hFFFF, c, "rx crc8");
		c = crcFold(16'h0000, a, p, 8);
		rdc(OFF_TRANSMIT_CRC, 16'hFFFF, c, "tx crc8");
		finalReport();
	end
endmodule // ssdcr_regs_tb_top
